// ### include/dual_comparator_pkg.sv
// Constants shared by the dual comparator control block
package dual_comparator_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  OFS_CMP_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_CORE_INT    = 8'h01;
  localparam logic [7:0]  OFS_PERIPH_FLAG = 8'h02;
  localparam logic [7:0]  OFS_PERIPH_EN   = 8'h03;
  localparam logic [7:0]  OFS_PORT_DATA   = 8'h04;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          SECOND_RESULT_BIT = 7;
  localparam int          FIRST_RESULT_BIT  = 6;
  localparam int          SECOND_INV_BIT    = 5;
  localparam int          FIRST_INV_BIT     = 4;
  localparam int          INPUT_SWITCH_BIT  = 3;
  localparam int          MODE_LSB          = 0;
  localparam int          MODE_W            = 3;
  localparam int          CHANGE_FLAG_BIT   = 6;
  localparam int          CHANGE_EN_BIT     = 6;
  localparam int          GLOBAL_EN_BIT     = 7;
  localparam int          PERIPH_EN_BIT     = 6;
  localparam int          PIN_A_BIT         = 3;
  localparam int          PIN_B_BIT         = 4;

  // ----------------------------------------------------------------
  // Modes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  MODE_RESET    = 3'h0;
  localparam logic [2:0]  MODE_INT_REF  = 3'h2;
  localparam logic [2:0]  MODE_PIN_OUT  = 3'h6;
  localparam logic [2:0]  MODE_OFF      = 3'h7;
  localparam logic [5:0]  CTRL_RESET    = 6'h00;
  localparam logic [6:0]  CORE_HI_RESET = 7'h00;
  localparam logic        CORE_B0_POR   = 1'h0;

endpackage

// ### logic/dual_comparator_control.sv
// Control, status, change detect and pin routing of the dual comparator
`timescale 1ns/1ps
module dual_comparator_control
  import dual_comparator_pkg::*;
(
  // Clock, resets, enable
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic                            porRstn,
  input  wire logic                            clkEn,
  // Register port
  input  wire logic [dual_comparator_pkg::ADDR_W-1:0] addr,
  input  wire logic [dual_comparator_pkg::DATA_W-1:0] wrData,
  input  wire logic                            wrStrobe,
  input  wire logic                            rdStrobe,
  output logic      [dual_comparator_pkg::DATA_W-1:0] rdData,
  // Analog front end
  input  wire logic                            firstRawCompare,
  input  wire logic                            secondRawCompare,
  output logic      [2:0]                      compareMode,
  output logic                                 inputSwitchSelect,
  output logic                                 comparatorsOff,
  output logic                                 internalRefPositive,
  // Port A pins
  input  wire logic [7:0]                      portLatch,
  input  wire logic [7:0]                      portDirection,
  input  wire logic [7:0]                      analogPinMask,
  input  wire logic [7:0]                      pinLevel,
  output logic      [7:0]                      pinOut,
  output logic      [7:0]                      pinOe,
  // Core
  input  wire logic                            sleepMode,
  output logic                                 irqRequest,
  output logic                                 wakeRequest
);
  import dual_comparator_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic       devRstn;
  logic [1:0] devSync;
  logic [1:0] porSync;
  logic       rstSyncN;
  logic       porSyncN;

  assign devRstn = rstn & porRstn;

  always_ff @(posedge clk or negedge devRstn) begin
    if (!devRstn) begin
      devSync <= 2'h0;
    end else begin
      devSync <= {devSync[0], 1'h1};
    end
  end

  always_ff @(posedge clk or negedge porRstn) begin
    if (!porRstn) begin
      porSync <= 2'h0;
    end else begin
      porSync <= {porSync[0], 1'h1};
    end
  end

  assign rstSyncN = devSync[1];
  assign porSyncN = porSync[1];

  // ----------------------------------------------------------------
  // Input synchronizers
  // ----------------------------------------------------------------
  logic [1:0] rawMeta;
  logic [1:0] rawSync;
  logic [7:0] pinMeta;
  logic [7:0] pinSync;

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rawMeta <= 2'h0;
      rawSync <= 2'h0;
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
    end else if (clkEn) begin
      rawMeta <= {secondRawCompare, firstRawCompare};
      rawSync <= rawMeta;
      pinMeta <= pinLevel;
      pinSync <= pinMeta;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0] ctrl;
  logic [6:0] coreHi;
  logic       coreB0;
  logic       changeFlag;
  logic       changeEnable;
  logic [1:0] latched;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire        selCtrl   = (addr == OFS_CMP_CTRL);
  wire        selCore   = (addr == OFS_CORE_INT);
  wire        selFlag   = (addr == OFS_PERIPH_FLAG);
  wire        selEn     = (addr == OFS_PERIPH_EN);
  wire        selPort   = (addr == OFS_PORT_DATA);
  wire        wrCtrl    = wrStrobe & selCtrl;
  wire        wrCore    = wrStrobe & selCore;
  wire        wrFlag    = wrStrobe & selFlag;
  wire        wrEn      = wrStrobe & selEn;
  wire        touchCtrl = (wrStrobe | rdStrobe) & selCtrl;
  wire [2:0]  mode      = ctrl[MODE_LSB +: MODE_W];
  wire        modeOff   = (mode == MODE_OFF);
  wire        modePins  = (mode == MODE_PIN_OUT);
  wire        globalEn  = coreHi[GLOBAL_EN_BIT-1];
  wire        periphEn  = coreHi[PERIPH_EN_BIT-1];

  wire [1:0]  invert    = {ctrl[SECOND_INV_BIT], ctrl[FIRST_INV_BIT]};
  wire [1:0]  resultNow = modeOff ? 2'h0 : (rawSync ^ invert);
  wire        mismatch  = (resultNow != latched);

  wire        next_changeFlag = mismatch | (wrFlag ? wrData[CHANGE_FLAG_BIT] : changeFlag);

  wire [7:0]  portRead  = pinSync & ~analogPinMask;
  wire [7:0]  ctrlRead  = {resultNow, ctrl};
  wire [7:0]  flagRead  = {1'h0, changeFlag, 6'h00};
  wire [7:0]  enRead    = {1'h0, changeEnable, 6'h00};
  wire [7:0]  coreRead  = {coreHi, coreB0};
  wire [7:0]  next_rdData = !rdStrobe ? 8'h00 :
                            selCtrl   ? ctrlRead :
                            selCore   ? coreRead :
                            selFlag   ? flagRead :
                            selEn     ? enRead :
                            selPort   ? portRead : 8'h00;

  wire        next_irq  = next_changeFlag & changeEnable & periphEn & globalEn;
  wire        next_wake = next_changeFlag & changeEnable & sleepMode;

  // ----------------------------------------------------------------
  // Control register and latched copy
  // ----------------------------------------------------------------
  // only reset or write alter
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ctrl <= CTRL_RESET;
    end else if (clkEn && wrCtrl) begin
      ctrl <= wrData[5:0];
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      latched <= 2'h0;
    end else if (clkEn && touchCtrl) begin
      latched <= resultNow;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt control registers
  // ----------------------------------------------------------------
  // upper bits on any reset
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      coreHi <= CORE_HI_RESET;
    end else if (clkEn && wrCore) begin
      coreHi <= wrData[7:1];
    end
  end

  always_ff @(posedge clk or negedge porSyncN) begin
    if (!porSyncN) begin
      coreB0 <= CORE_B0_POR;
    end else if (clkEn && wrCore && rstSyncN) begin
      coreB0 <= wrData[0];
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      changeFlag   <= 1'h0;
      changeEnable <= 1'h0;
    end else if (clkEn) begin
      changeFlag <= next_changeFlag;
      if (wrEn) begin
        changeEnable <= wrData[CHANGE_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rdData              <= 8'h00;
      irqRequest          <= 1'h0;
      wakeRequest         <= 1'h0;
      compareMode         <= MODE_RESET;
      inputSwitchSelect   <= 1'h0;
      comparatorsOff      <= 1'h1;
      internalRefPositive <= 1'h0;
    end else if (clkEn) begin
      rdData              <= next_rdData;
      irqRequest          <= next_irq;
      wakeRequest         <= next_wake;
      compareMode         <= mode;
      inputSwitchSelect   <= ctrl[INPUT_SWITCH_BIT];
      comparatorsOff      <= modeOff;
      internalRefPositive <= (mode == MODE_INT_REF);
    end
  end

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  // Unsynchronized path on purpose
  wire        pinAValue = modePins ? (firstRawCompare ^ invert[0]) : portLatch[PIN_A_BIT];
  wire        pinBValue = modePins ? (secondRawCompare ^ invert[1]) : portLatch[PIN_B_BIT];

  always_comb begin
    pinOut            = portLatch;
    pinOut[PIN_A_BIT] = pinAValue;
    pinOut[PIN_B_BIT] = pinBValue;
  end

  assign pinOe = ~portDirection;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  property p_result_read;
    clkEn && rdStrobe && selCtrl |=> rdData[7:6] == $past(resultNow);
  endproperty
  a_result_read: assert property (p_result_read) else $error("result bits read wrong");

  property p_pin_route;
    modePins |-> pinOut[PIN_B_BIT:PIN_A_BIT] == ({secondRawCompare, firstRawCompare} ^ invert);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("pins not routed in mode 110");

  property p_pin_plain;
    !modePins |-> pinOut == portLatch;
  endproperty
  a_pin_plain: assert property (p_pin_plain) else $error("pins not plain port data");

  property p_pin_enable;
    pinOe[PIN_B_BIT:PIN_A_BIT] == ~portDirection[PIN_B_BIT:PIN_A_BIT];
  endproperty
  a_pin_enable: assert property (p_pin_enable) else $error("direction ignored on pin");

  property p_port_analog;
    clkEn && rdStrobe && selPort |=> (rdData & $past(analogPinMask)) == 8'h00;
  endproperty
  a_port_analog: assert property (p_port_analog) else $error("analog pin read nonzero");

  property p_mismatch_sets;
    clkEn && mismatch |=> changeFlag;
  endproperty
  a_mismatch_sets: assert property (p_mismatch_sets) else $error("mismatch did not set flag");

  property p_sw_clear;
    clkEn && wrFlag && !wrData[CHANGE_FLAG_BIT] && !mismatch |=> !changeFlag;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("flag clear failed");

  property p_sw_set;
    clkEn && wrFlag && wrData[CHANGE_FLAG_BIT] |=> changeFlag;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("flag set by write failed");

  property p_irq_gate;
    clkEn && !(changeEnable && periphEn && globalEn) |=> !irqRequest;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt gating wrong");

  property p_latch_refresh;
    clkEn && touchCtrl |=> latched == $past(resultNow);
  endproperty
  a_latch_refresh: assert property (p_latch_refresh) else $error("latched copy not refreshed");

  property p_off_mode;
    clkEn && modeOff |=> comparatorsOff && (!$past(rdStrobe) || !$past(selCtrl) || rdData[7:6] == 2'h0);
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("mode 111 not off");

  property p_reset_state;
    $rose(rstSyncN) |-> ctrl == CTRL_RESET && comparatorsOff && coreHi == CORE_HI_RESET;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

  property p_int_ref;
    clkEn && mode == MODE_INT_REF |=> internalRefPositive;
  endproperty
  a_int_ref: assert property (p_int_ref) else $error("internal reference not selected");

  c_flag_by_change: cover property (clkEn && !changeFlag && mismatch ##1 changeFlag);
  c_irq_raised: cover property (!irqRequest ##1 irqRequest);
  c_wake_raised: cover property (sleepMode && !wakeRequest ##1 wakeRequest);
  c_pin_mode: cover property (modePins && pinOe[PIN_A_BIT]);

endmodule

// ### tb/comparator_front_end.sv
// Behavioural model of the analog comparators and the port pins
`timescale 1ns/1ps
module comparator_front_end (
  // Analog levels in millivolts
  input  wire logic [11:0] firstPos,
  input  wire logic [11:0] firstNeg,
  input  wire logic [11:0] secondPos,
  input  wire logic [11:0] secondNeg,
  input  wire logic        comparatorsOff,
  // Pin side
  input  wire logic [7:0]  pinOut,
  input  wire logic [7:0]  pinOe,
  input  wire logic [7:0]  extLevel,
  output logic             firstRawCompare,
  output logic             secondRawCompare,
  output logic [7:0]       pinLevel
);
  // result polarity, off when powered down
  assign firstRawCompare  = !comparatorsOff && (firstPos > firstNeg);
  assign secondRawCompare = !comparatorsOff && (secondPos > secondNeg);
  // Driven pins show the block, others the outside level
  assign pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// ### tb/dual_comparator_control_bench.sv
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ps
module dual_comparator_control_bench;
  import dual_comparator_pkg::*;
  logic clk, rstn, porRstn, wrStrobe, rdStrobe, sleepMode;
  logic [7:0] addr, wrData, rdData, portLatch, portDirection, analogPinMask, pinLevel, pinOut, pinOe, extLevel;
  logic [2:0] compareMode;
  logic inputSwitchSelect, comparatorsOff, internalRefPositive, irqRequest, wakeRequest;
  logic firstRawCompare, secondRawCompare;
  logic [11:0] firstPos, firstNeg, secondPos, secondNeg;
  logic [7:0] got;
  int failures = 0;
  int samples_checked = 0;

  dual_comparator_control dut (.clk(clk), .rstn(rstn), .porRstn(porRstn), .clkEn(1'b1), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .firstRawCompare(firstRawCompare), .secondRawCompare(secondRawCompare), .compareMode(compareMode),
    .inputSwitchSelect(inputSwitchSelect), .comparatorsOff(comparatorsOff),
    .internalRefPositive(internalRefPositive), .portLatch(portLatch), .portDirection(portDirection),
    .analogPinMask(analogPinMask), .pinLevel(pinLevel), .pinOut(pinOut), .pinOe(pinOe),
    .sleepMode(sleepMode), .irqRequest(irqRequest), .wakeRequest(wakeRequest));

  comparator_front_end front (.firstPos(firstPos), .firstNeg(firstNeg), .secondPos(secondPos),
    .secondNeg(secondNeg), .comparatorsOff(comparatorsOff), .pinOut(pinOut), .pinOe(pinOe),
    .extLevel(extLevel), .firstRawCompare(firstRawCompare), .secondRawCompare(secondRawCompare),
    .pinLevel(pinLevel));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr     <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr     <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    got = rdData;
  endtask

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic seen);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic power);
    @(posedge clk);
    rstn <= 1'b0;
    porRstn <= !power;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    porRstn <= 1'b1;
    pause(3);
  endtask

  task test_done;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #(3000 * 50);
    failures++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, porRstn, wrStrobe, rdStrobe, sleepMode} = 5'h00;
    {addr, wrData, portLatch, analogPinMask, extLevel} = 40'h00;
    portDirection = 8'h08;
    {firstPos, firstNeg, secondPos, secondNeg} = {12'h100, 12'h200, 12'h100, 12'h200};
    do_reset(1'b1);
    rd(OFS_CMP_CTRL);
    check8("ctrl reset", 8'h00, got);
    check8("mode reset", 8'h00, {5'h00, compareMode});
    wr(OFS_CMP_CTRL, 8'hFF);
    rd(OFS_CMP_CTRL);
    check8("ctrl off", 8'h3F, got);
    check1("off", 1'b1, comparatorsOff);
    check8("mode off", 8'h07, {5'h00, compareMode});
    firstPos <= 12'h300;
    wr(OFS_CMP_CTRL, 8'hC6);
    pause(5);
    rd(OFS_CMP_CTRL);
    check8("ctrl routed", 8'h46, got);
    check8("pins routed", {3'h0, 2'b01, 3'h0}, pinOut & 8'h18);
    check8("pin enables", ~portDirection, pinOe);
    wr(OFS_CMP_CTRL, 8'h16);
    pause(5);
    rd(OFS_CMP_CTRL);
    check8("ctrl inverted", 8'h16, got);
    wr(OFS_CMP_CTRL, 8'h06);
    pause(5);
    rd(OFS_CMP_CTRL);
    wr(OFS_PERIPH_FLAG, 8'h00);
    secondPos <= 12'h300;
    pause(6);
    rd(OFS_PERIPH_FLAG);
    check8("flag no enables", 8'h40, got);
    check1("irq disabled", 1'b0, irqRequest);
    wr(OFS_CORE_INT, 8'hC0);
    wr(OFS_PERIPH_EN, 8'h40);
    pause(2);
    check1("irq enabled", 1'b1, irqRequest);
    wr(OFS_PERIPH_FLAG, 8'h00);
    rd(OFS_PERIPH_FLAG);
    check8("flag held", 8'h40, got);
    rd(OFS_CMP_CTRL);
    check8("ctrl both high", 8'hC6, got);
    wr(OFS_PERIPH_FLAG, 8'h00);
    rd(OFS_PERIPH_FLAG);
    check8("flag cleared", 8'h00, got);
    pause(2);
    check1("irq cleared", 1'b0, irqRequest);
    wr(OFS_PERIPH_FLAG, 8'h40);
    rd(OFS_PERIPH_FLAG);
    check8("flag by write", 8'h40, got);
    wr(OFS_PERIPH_FLAG, 8'h00);
    sleepMode <= 1'b1;
    firstPos <= 12'h050;
    pause(6);
    check1("wake", 1'b1, wakeRequest);
    @(posedge clk);
    sleepMode <= 1'b0;
    rd(OFS_CMP_CTRL);
    check8("ctrl after wake", 8'h86, got);
    wr(OFS_CMP_CTRL, 8'h02);
    pause(2);
    check1("internal ref", 1'b1, internalRefPositive);
    wr(OFS_CMP_CTRL, 8'h07);
    pause(2);
    rd(OFS_CMP_CTRL);
    check8("ctrl mode off", 8'h07, got);
    wr(OFS_CMP_CTRL, 8'h00);
    portLatch <= 8'h10;
    pause(2);
    check8("pins plain", 8'h10, pinOut & 8'h18);
    @(posedge clk);
    portDirection <= 8'hFF;
    analogPinMask <= 8'h0F;
    extLevel <= 8'hFF;
    pause(4);
    rd(OFS_PORT_DATA);
    check8("port data", 8'hF0, got);
    wr(OFS_CMP_CTRL, 8'h1D);
    wr(OFS_CORE_INT, 8'hFF);
    do_reset(1'b0);
    rd(OFS_CORE_INT);
    check8("core warm reset", 8'h01, got);
    rd(OFS_CMP_CTRL);
    check8("ctrl warm reset", 8'h00, got & 8'h3F);
    check1("switch warm reset", 1'b0, inputSwitchSelect);
    do_reset(1'b1);
    rd(OFS_CORE_INT);
    check8("core power reset", 8'h00, got);
    test_done();
  end
endmodule
